/* File: rtl/tcc_pkg.sv */
package tcc_pkg;
  localparam int unsigned ADDR_W = 12;

  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_STATUS = 10'h040;
  localparam logic [9:0] IDX_CNT_HI = 10'h041;
  localparam logic [9:0] IDX_CNT_LO = 10'h042;
  localparam logic [9:0] IDX_MOD_HI = 10'h043;
  localparam logic [9:0] IDX_MOD_LO = 10'h044;
  localparam logic [9:0] IDX_CH0_CTL = 10'h045;
  localparam logic [9:0] IDX_CH0_HI = 10'h046;
  localparam logic [9:0] IDX_CH0_LO = 10'h047;
  localparam logic [9:0] IDX_CH1_CTL = 10'h048;
  localparam logic [9:0] IDX_CH1_HI = 10'h049;
  localparam logic [9:0] IDX_CH1_LO = 10'h04A;
  localparam logic [9:0] IDX_STRIDE = 10'h003;

  // timer_status_control fields
  localparam int unsigned ST_OVF = 7;
  localparam int unsigned ST_OVIE = 6;
  localparam int unsigned ST_STOP = 5;
  localparam int unsigned ST_RST = 4;

  // channel control fields
  localparam int unsigned CC_FLAG = 7;
  localparam int unsigned CC_IE = 6;
  localparam int unsigned CC_MSB = 5;
  localparam int unsigned CC_MSA = 4;
  localparam int unsigned CC_ELSB = 3;
  localparam int unsigned CC_ELSA = 2;
  localparam int unsigned CC_TOV = 1;
  localparam int unsigned CC_MAX = 0;

  // edge/level select: capture edge, or compare action
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_ANY_SET = 2'h3;

  localparam logic [2:0] PS_EXT = 3'h7;
  localparam logic [15:0] MOD_RST = 16'hFFFF;
  localparam logic [7:0] CH1_CTL_MASK = 8'hDF;
  localparam logic [7:0] ST_RD_MASK = 8'hE7;
endpackage : tcc_pkg

/* File: rtl/tcc_timer.sv */
// Operation
// - 16-bit up-counter, free-running or modulo
// - modulo limit from high/low modulo registers
// - counter readable without disturbing counting
// - prescaler select: seven bus rates or pin
// - each channel independently capture or compare
// - capture on rising, falling or any edge
// - selected edge copies counter into channel value
// - capture happens whether flag set or not
// - captured value stored two bus cycles later
// - capture sets flag, irq if enabled
// - next capture overwrites earlier captured value
// - channel values untouched by reset
// - compare match sets, clears or toggles pin
// - compare match can request interrupt
// - per-channel toggle pin on overflow
// - status register bit layout
// - channel control register bit layout
// - 16-bit values as high then low byte
// - linked channels: last written controls pin
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // timer pins
  input wire logic ext_clk_i,
  input wire logic [1:0] ch_in_i,
  output logic [1:0] ch_out_o,
  output logic [1:0] ch_oe_o,
  // interrupt request
  output logic irq_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [5:0] psc;
    logic [15:0] modv;
    logic ovf_flag;
    logic ovf_ie;
    logic stop;
    logic [2:0] ps;
    logic ext_prev;
    logic [1:0][7:0] ctl;
    logic [1:0][15:0] val;
    logic [1:0] pin;
    logic [1:0] pin_prev;
    logic [1:0] cap_pend;
    logic [1:0][15:0] cap_snap;
    logic lnk_act;
    logic lnk_pend;
    logic lo_held;
    logic [7:0] lo_latch;
    logic [31:0] rdata;
  } tcc_state_t;

  tcc_state_t state_r;
  tcc_state_t state_nxt;

  function automatic logic [9:0] tcc_index(input logic [tcc_pkg::ADDR_W-1:0] a);
    tcc_index = a[tcc_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic tcc_mapped(input logic [tcc_pkg::ADDR_W-1:0] a);
    tcc_mapped = (a[1:0] == 2'h0) && (tcc_index(a) >= tcc_pkg::IDX_STATUS)
                 && (tcc_index(a) <= tcc_pkg::IDX_CH1_LO);
  endfunction

  // divide-by-2^ps tick from the free-running prescaler
  function automatic logic tcc_tick(input logic [5:0] psc, input logic [2:0] ps);
    logic [5:0] mask;
    mask = 6'((7'h01 << ps) - 7'h01);
    tcc_tick = ((psc & mask) == mask);
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic rd_setup;
  logic tick;
  logic ovf;
  logic linked;
  logic [9:0] idx;
  logic [7:0] wb;
  logic [1:0] els;
  logic cap_mode;
  logic cmp_mode;
  logic edge_hit;
  logic [15:0] cval;
  logic [15:0] keep_val;
  int unsigned ch_base;

  always_comb begin
    state_nxt = state_r;
    idx = tcc_index(paddr_i);
    wb = pwdata_i[7:0];
    wr_acc = psel_i && penable_i && pwrite_i && tcc_mapped(paddr_i);
    rd_acc = psel_i && penable_i && !pwrite_i && tcc_mapped(paddr_i);
    rd_setup = psel_i && !penable_i;
    linked = state_r.ctl[0][tcc_pkg::CC_MSB];
    tick = 1'b0;
    ovf = 1'b0;
    els = tcc_pkg::ELS_OFF;
    cap_mode = 1'b0;
    cmp_mode = 1'b0;
    edge_hit = 1'b0;
    cval = 16'h0000;
    keep_val = 16'h0000;
    ch_base = 0;

    state_nxt.ext_prev = ext_clk_i;
    if (!state_r.stop) begin
      state_nxt.psc = state_r.psc + 6'h01;
      if (state_r.ps == tcc_pkg::PS_EXT) begin
        tick = ext_clk_i && !state_r.ext_prev;
      end else begin
        tick = tcc_tick(state_r.psc, state_r.ps);
      end
    end

    if (tick) begin
      if (state_r.cnt == state_r.modv) begin
        state_nxt.cnt = 16'h0000;
        ovf = 1'b1;
      end else begin
        state_nxt.cnt = state_r.cnt + 16'h0001;
      end
    end

    // coherent counter read via low-byte latch
    // latch in the setup cycle, the same cycle that loads the high byte
    if (rd_setup && !pwrite_i && tcc_mapped(paddr_i) && idx == tcc_pkg::IDX_CNT_HI) begin
      state_nxt.lo_held = 1'b1;
      state_nxt.lo_latch = state_r.cnt[7:0];
    end
    if (rd_acc && idx == tcc_pkg::IDX_CNT_LO) begin
      state_nxt.lo_held = 1'b0;
    end

    // register writes; hardware sets below take priority
    if (wr_acc) begin
      case (idx)
        tcc_pkg::IDX_STATUS: begin
          state_nxt.ovf_ie = wb[tcc_pkg::ST_OVIE];
          state_nxt.stop = wb[tcc_pkg::ST_STOP];
          state_nxt.ps = wb[2:0];
          if (!wb[tcc_pkg::ST_OVF]) begin
            state_nxt.ovf_flag = 1'b0;
          end
          if (wb[tcc_pkg::ST_RST]) begin
            state_nxt.cnt = 16'h0000;
            state_nxt.psc = 6'h00;
          end
        end
        tcc_pkg::IDX_MOD_HI: state_nxt.modv[15:8] = wb;
        tcc_pkg::IDX_MOD_LO: state_nxt.modv[7:0] = wb;
        tcc_pkg::IDX_CH0_CTL, tcc_pkg::IDX_CH1_CTL: begin
          ch_base = (idx == tcc_pkg::IDX_CH0_CTL) ? 0 : 1;
          // control layout, flag cleared by writing zero
          state_nxt.ctl[ch_base][6:0] = wb[6:0] & ((ch_base == 1) ? tcc_pkg::CH1_CTL_MASK[6:0] : 7'h7F);
          if (!wb[tcc_pkg::CC_FLAG]) begin
            state_nxt.ctl[ch_base][tcc_pkg::CC_FLAG] = 1'b0;
          end
        end
        tcc_pkg::IDX_CH0_HI: begin
          state_nxt.val[0][15:8] = wb;
          state_nxt.lnk_pend = 1'b0;
        end
        tcc_pkg::IDX_CH0_LO: begin
          state_nxt.val[0][7:0] = wb;
          state_nxt.lnk_pend = 1'b0;
        end
        tcc_pkg::IDX_CH1_HI: begin
          state_nxt.val[1][15:8] = wb;
          state_nxt.lnk_pend = 1'b1;
        end
        tcc_pkg::IDX_CH1_LO: begin
          state_nxt.val[1][7:0] = wb;
          state_nxt.lnk_pend = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // overflow flag, set wins over clear
    if (ovf) begin
      state_nxt.ovf_flag = 1'b1;
    end

    // linked pair swaps active value at overflow
    if (!linked) begin
      state_nxt.lnk_act = 1'b0;
      state_nxt.lnk_pend = 1'b0;
    end else if (ovf) begin
      state_nxt.lnk_act = state_nxt.lnk_pend;
    end

    for (int i = 0; i < 2; i++) begin
      els = {state_r.ctl[i][tcc_pkg::CC_ELSB], state_r.ctl[i][tcc_pkg::CC_ELSA]};
      // per-channel mode; ch1 idle while linked
      cmp_mode = (state_r.ctl[i][tcc_pkg::CC_MSA] || state_r.ctl[i][tcc_pkg::CC_MSB])
                 && !(i == 1 && linked);
      cap_mode = !cmp_mode && !(i == 1 && linked) && (els != tcc_pkg::ELS_OFF);
      state_nxt.pin_prev[i] = ch_in_i[i];

      case (els)
        tcc_pkg::ELS_RISE_TOGGLE: edge_hit = ch_in_i[i] && !state_r.pin_prev[i];
        tcc_pkg::ELS_FALL_CLEAR: edge_hit = !ch_in_i[i] && state_r.pin_prev[i];
        tcc_pkg::ELS_ANY_SET: edge_hit = ch_in_i[i] != state_r.pin_prev[i];
        default: edge_hit = 1'b0;
      endcase

      state_nxt.cap_pend[i] = cap_mode && edge_hit;
      if (cap_mode && edge_hit) begin
        state_nxt.cap_snap[i] = state_r.cnt;
      end
      if (state_r.cap_pend[i]) begin
        state_nxt.val[i] = state_r.cap_snap[i];
        state_nxt.ctl[i][tcc_pkg::CC_FLAG] = 1'b1;
      end

      // compare action when the counter reaches the value
      cval = (i == 0 && linked) ? state_r.val[state_r.lnk_act] : state_r.val[i];
      if (cmp_mode && tick && state_nxt.cnt == cval) begin
        state_nxt.ctl[i][tcc_pkg::CC_FLAG] = 1'b1;
        if (!state_r.ctl[i][tcc_pkg::CC_MAX]) begin
          case (els)
            tcc_pkg::ELS_RISE_TOGGLE: state_nxt.pin[i] = !state_r.pin[i];
            tcc_pkg::ELS_FALL_CLEAR: state_nxt.pin[i] = 1'b0;
            tcc_pkg::ELS_ANY_SET: state_nxt.pin[i] = 1'b1;
            default: state_nxt.pin[i] = state_r.pin[i];
          endcase
        end
      end
      // toggle on overflow; full duty holds pin high
      if (cmp_mode && ovf && state_r.ctl[i][tcc_pkg::CC_TOV]) begin
        state_nxt.pin[i] = state_r.ctl[i][tcc_pkg::CC_MAX] ? 1'b1 : !state_nxt.pin[i];
      end
    end

    // read data prepared in the setup phase
    if (rd_setup) begin
      state_nxt.rdata = 32'h0000_0000;
      // refused accesses read zero
      case (tcc_mapped(paddr_i) ? idx : 10'h000)
        tcc_pkg::IDX_STATUS:
          state_nxt.rdata[7:0] = {state_r.ovf_flag, state_r.ovf_ie, state_r.stop, 2'h0, state_r.ps};
        tcc_pkg::IDX_CNT_HI: state_nxt.rdata[7:0] = state_r.cnt[15:8];
        tcc_pkg::IDX_CNT_LO:
          state_nxt.rdata[7:0] = state_r.lo_held ? state_r.lo_latch : state_r.cnt[7:0];
        tcc_pkg::IDX_MOD_HI: state_nxt.rdata[7:0] = state_r.modv[15:8];
        tcc_pkg::IDX_MOD_LO: state_nxt.rdata[7:0] = state_r.modv[7:0];
        tcc_pkg::IDX_CH0_CTL: state_nxt.rdata[7:0] = state_r.ctl[0];
        tcc_pkg::IDX_CH0_HI: state_nxt.rdata[7:0] = state_r.val[0][15:8];
        tcc_pkg::IDX_CH0_LO: state_nxt.rdata[7:0] = state_r.val[0][7:0];
        tcc_pkg::IDX_CH1_CTL: state_nxt.rdata[7:0] = state_r.ctl[1];
        tcc_pkg::IDX_CH1_HI: state_nxt.rdata[7:0] = state_r.val[1][15:8];
        tcc_pkg::IDX_CH1_LO: state_nxt.rdata[7:0] = state_r.val[1][7:0];
        default: state_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // reset loads defaults (modulo FFFF, stopped) into all but the channel values
    if (sys_rst_i) begin
      for (int i = 0; i < 2; i++) begin
        keep_val = state_r.val[i];
        state_nxt.val[i] = keep_val;
      end
      state_nxt.cnt = 16'h0000;
      state_nxt.psc = 6'h00;
      state_nxt.modv = tcc_pkg::MOD_RST;
      state_nxt.ovf_flag = 1'b0;
      state_nxt.ovf_ie = 1'b0;
      state_nxt.stop = 1'b1;
      state_nxt.ps = 3'h0;
      state_nxt.ext_prev = 1'b0;
      state_nxt.ctl = '0;
      state_nxt.pin = 2'h0;
      state_nxt.pin_prev = 2'h0;
      state_nxt.cap_pend = 2'h0;
      state_nxt.cap_snap = '0;
      state_nxt.lnk_act = 1'b0;
      state_nxt.lnk_pend = 1'b0;
      state_nxt.lo_held = 1'b0;
      state_nxt.lo_latch = 8'h00;
      state_nxt.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    state_r <= state_nxt;
  end

  // zero-wait slave; unmapped or misaligned access is an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !tcc_mapped(paddr_i);
  assign prdata_o = state_r.rdata;

  assign ch_out_o = state_r.pin;
  assign ch_oe_o[0] = (state_r.ctl[0][tcc_pkg::CC_MSA] || state_r.ctl[0][tcc_pkg::CC_MSB])
                      && ({state_r.ctl[0][tcc_pkg::CC_ELSB], state_r.ctl[0][tcc_pkg::CC_ELSA]} != tcc_pkg::ELS_OFF);
  assign ch_oe_o[1] = state_r.ctl[1][tcc_pkg::CC_MSA] && !state_r.ctl[0][tcc_pkg::CC_MSB]
                      && ({state_r.ctl[1][tcc_pkg::CC_ELSB], state_r.ctl[1][tcc_pkg::CC_ELSA]} != tcc_pkg::ELS_OFF);

  assign irq_o = (state_r.ovf_flag && state_r.ovf_ie)
                 || (state_r.ctl[0][tcc_pkg::CC_FLAG] && state_r.ctl[0][tcc_pkg::CC_IE])
                 || (state_r.ctl[1][tcc_pkg::CC_FLAG] && state_r.ctl[1][tcc_pkg::CC_IE]);

endmodule // tcc_timer

`default_nettype wire

/* File: testbench/tcc_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
  // clock
  input wire logic clk_i,
  // pins toward the timer
  output logic ext_clk_o,
  output logic [1:0] ch_in_o,
  input wire logic [1:0] ch_out_i,
  input wire logic [1:0] ch_oe_i
);
  initial begin
    ext_clk_o = 1'b0;
    ch_in_o = 2'h0;
  end
  // wide pulses so a synchroniser never misses an edge
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask
  // holds long enough for capture to land
  task automatic set_in(input int ch, input logic v);
    @(posedge clk_i);
    ch_in_o[ch] <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // tcc_pins
`default_nettype wire

/* File: testbench/tcc_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // timer pins
  input wire logic ext_clk_i,
  input wire logic [1:0] ch_in_i,
  input wire logic [1:0] ch_out_o,
  input wire logic [1:0] ch_oe_o,
  input wire logic irq_o
);
  logic setup_rd;
  logic access;
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign access = psel_i && penable_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_PREADY: assert property (access |-> pready_o)
    else $error("access not answered");
  AST_RD_HI: assert property (access && !pwrite_i |-> prdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_MISALIGN: assert property (access && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("misaligned access not refused");
  AST_MAPPED: assert property (access && paddr_i[1:0] == 2'h0 && paddr_i[11:2] >= tcc_pkg::IDX_STATUS
    && paddr_i[11:2] <= tcc_pkg::IDX_CH1_LO |-> !pslverr_o)
    else $error("mapped access refused");
  // pins and irq must be quiet right after a reset edge
  AST_RESET: assert property (disable iff (1'b0) sys_rst_i |=> ch_oe_o == 2'h0 && ch_out_o == 2'h0 && !irq_o)
    else $error("outputs active after reset");
  AST_STATUS_RD: assert property (setup_rd && paddr_i == 12'h100 |=> prdata_o[4:3] == 2'h0)
    else $error("status bits 4:3 not zero");
  AST_CH1_RD: assert property (setup_rd && paddr_i == 12'h120 |=> prdata_o[5] == 1'b0)
    else $error("channel 1 bit 5 not zero");
  AST_UNMAPPED: assert property (setup_rd && paddr_i[11:2] > tcc_pkg::IDX_CH1_LO |=> prdata_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule // tcc_timer_props
bind tcc_timer tcc_timer_props i_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i), .ch_in_i(ch_in_i),
  .ch_out_o(ch_out_o), .ch_oe_o(ch_oe_o), .irq_o(irq_o));
`default_nettype wire

/* File: testbench/test_two_channel_capture_compare_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_two_channel_capture_compare_timer;
  logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, ext_clk_i, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [1:0] ch_in_i, ch_out_o, ch_oe_o;
  logic [31:0] seed = 32'h00000039;
  int fails = 0, num_checks = 0, cnt = 0, md = 9, ovf = 0, capt = 0, k;
  tcc_timer i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i), .ch_in_i(ch_in_i), .ch_out_o(ch_out_o),
    .ch_oe_o(ch_oe_o), .irq_o(irq_o));
  tcc_pins i_pins (.clk_i(clk_i), .ext_clk_o(ext_clk_i), .ch_in_o(ch_in_i), .ch_out_i(ch_out_o),
    .ch_oe_i(ch_oe_o));
  function int rnd(input int lim);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 1 + int'(seed[15:0]) % lim;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk_rd(input logic [11:0] a, input int e, input string nm);
    apb(1'b0, a, 8'h00);
    `CHK(nm, 32'(e), rd)
  endtask
  task automatic chk_cnt();
    chk_rd(12'h104, cnt >> 8, "cnt_hi");
    chk_rd(12'h108, cnt & 255, "cnt_lo");
  endtask
  // model advance: wrap after the modulo value
  task automatic ticks(input int n);
    i_pins.ext_pulses(n);
    repeat (n) begin
      if (cnt == md) begin
        cnt = 0;
        ovf = 1;
      end else begin
        cnt++;
      end
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
  initial begin
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_rd(12'h100, 'h20, "status");
    chk_rd(12'h10C, 'hFF, "mod_hi");
    chk_rd(12'h114, 0, "ch0_ctl");
    chk_rd(12'h120, 0, "ch1_ctl");
    chk_rd(12'h200, 0, "unmapped");
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, 12'h101, 8'h00);
    `CHK("misaligned err", 1'b1, err)
    apb(1'b1, 12'h10C, 8'h00);
    apb(1'b1, 12'h110, 8'(md));
    // external clock source keeps the count exact
    apb(1'b1, 12'h100, 8'h07);
    ticks(rnd(12));
    chk_cnt();
    chk_cnt();
    chk_rd(12'h100, 7 | ovf << 7, "status");
    for (int els = 1; els < 4; els++) begin
      apb(1'b1, 12'h114, 8'(32'h40 | els << 2));
      ticks(rnd(4));
      i_pins.set_in(0, 1'b1);
      if (els != 2) capt = cnt;
      ticks(rnd(4));
      i_pins.set_in(0, 1'b0);
      if (els != 1) capt = cnt;
      chk_rd(12'h118, capt >> 8, "cap_hi");
      chk_rd(12'h11C, capt & 255, "cap_lo");
      chk_rd(12'h114, 'hC0 | els << 2, "ch0_ctl");
      @(negedge clk_i);
      `CHK("irq", 1'b1, irq_o)
    end
    apb(1'b1, 12'h114, 8'h40);
    @(negedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    for (int els = 3; els > 0; els--) begin
      k = rnd(3);
      apb(1'b1, 12'h124, 8'h00);
      apb(1'b1, 12'h128, 8'((cnt + k) % (md + 1)));
      apb(1'b1, 12'h120, 8'(32'h10 | els << 2));
      ticks(k);
      @(negedge clk_i);
      `CHK("ch1 pin", 2'((els % 2) * 2 + 1), {ch_out_o[1], ch_oe_o[1]})
      chk_rd(12'h120, 'h90 | els << 2, "ch1_ctl");
    end
    apb(1'b1, 12'h100, 8'h47);
    apb(1'b1, 12'h114, 8'h12);
    ticks(md + 1);
    @(negedge clk_i);
    `CHK("ch0 tov", 1'b1, ch_out_o[0])
    `CHK("ovf irq", 1'b1, irq_o)
    apb(1'b1, 12'h100, 8'h27);
    i_pins.ext_pulses(3);
    chk_cnt();
    apb(1'b1, 12'h100, 8'h37);
    cnt = 0;
    chk_cnt();
    chk_rd(12'h100, 'h27, "status");
    report_and_stop();
  end
endmodule // test_two_channel_capture_compare_timer
`default_nettype wire
